// ---- design/dd_dev_end.sv ----
// Converter end: receives 24-bit write frames and holds the input, DAC and mode registers.
// Assumes the link is sampled by core_clk, so the serial clock must be well below core_clk/4.
`timescale 1ns/1ns
`include "dd_consts.svh"
module dd_dev_end
    import dd_pkg::*;
#(
    parameter bit MIDSCALE = 1'b0
)(
    input  wire logic   core_clk,
    input  wire logic   rst,
    dd_link_if.dev      link,
    output logic [15:0] in_a_q,
    output logic [15:0] in_b_q,
    output logic [15:0] dac_a_q,
    output logic [15:0] dac_b_q,
    output logic [1:0]  gain_two_q,
    output logic [3:0]  power_mode_q,
    output logic [1:0]  load_dac_n_off_q,
    output logic        ref_en_q,
    output logic        clear_mode_q,
    output logic        frame_done_q
);
    localparam logic [15:0] CLR_CODE = MIDSCALE ? `DD_MID_CODE : `DD_ZERO_CODE;

    // Bit order: sync_n, sclk, din, clear_in_n, load_dac_n.
    logic [4:0]  meta_q;
    logic [4:0]  sync_q;
    logic [4:0]  prev_q;
    dd_rx_e      rx_q;
    logic [4:0]  cnt_q;
    logic [23:0] shreg_q;
    logic        exec_q;
    logic        clr_armed_q;

    logic        frame_fall;
    logic        frame_rise;
    logic        sclk_fall;
    logic        clear_fall;
    logic        load_dac_n_fall;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 5'h1F;
            sync_q <= 5'h1F;
            prev_q <= 5'h1F;
        end else begin
            meta_q <= {link.sync_n, link.sclk, link.din, link.clear_in_n, link.load_dac_n};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign frame_fall = prev_q[4] & ~sync_q[4];
    assign frame_rise = ~prev_q[4] & sync_q[4];
    assign sclk_fall  = prev_q[3] & ~sync_q[3] & ~sync_q[4];
    assign clear_fall = prev_q[1] & ~sync_q[1];
    assign load_dac_n_fall  = prev_q[0] & ~sync_q[0];

    // Receive sequencer: shift, lock at 24, discard on early frame-select rise.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_q    <= DD_RX_IDLE;
            cnt_q   <= 5'h00;
            shreg_q <= 24'h000000;
            exec_q  <= 1'b0;
        end else begin
            exec_q <= 1'b0;
            unique case (rx_q)
                DD_RX_IDLE: begin
                    if (frame_fall) begin
                        rx_q    <= DD_RX_SHIFT;
                        cnt_q   <= 5'h00;
                        shreg_q <= 24'h000000;
                    end
                end
                DD_RX_SHIFT: begin
                    if (frame_rise) begin
                        rx_q    <= DD_RX_IDLE;
                        cnt_q   <= 5'h00;
                        shreg_q <= 24'h000000;
                    end else if (sclk_fall) begin
                        shreg_q <= {shreg_q[22:0], sync_q[2]};
                        cnt_q   <= cnt_q + 5'h01;
                        if (cnt_q == `DD_WORD_BITS - 5'h01) begin
                            rx_q   <= DD_RX_LOCKED;
                            exec_q <= 1'b1;
                        end
                    end
                end
                DD_RX_LOCKED: begin
                    // Further edges are ignored; a new frame needs a fresh falling select.
                    if (frame_fall) begin
                        rx_q    <= DD_RX_SHIFT;
                        cnt_q   <= 5'h00;
                        shreg_q <= 24'h000000;
                    end else if (frame_rise) begin
                        rx_q <= DD_RX_IDLE;
                    end
                end
                default: rx_q <= DD_RX_IDLE;
            endcase
        end
    end

    // Field decode of the locked word.
    logic [2:0]  cmd;
    logic [2:0]  addr;
    logic [15:0] data;
    logic        sel_a;
    logic        sel_b;
    logic        wr_a;
    logic        wr_b;
    logic        upd_a;
    logic        upd_b;
    logic        wr_gain;
    logic        sw_reset;

    always_comb begin
        cmd      = shreg_q[`DD_CMD_HI:`DD_CMD_LO];
        addr     = shreg_q[`DD_ADDR_HI:`DD_ADDR_LO];
        data     = shreg_q[15:0];
        sel_a    = (addr == `DD_ADDR_A) || (addr == `DD_ADDR_BOTH);
        sel_b    = (addr == `DD_ADDR_B) || (addr == `DD_ADDR_BOTH);
        wr_a     = 1'b0;
        wr_b     = 1'b0;
        upd_a    = 1'b0;
        upd_b    = 1'b0;
        wr_gain  = 1'b0;
        sw_reset = 1'b0;
        if (exec_q) begin
            unique case (cmd)
                `DD_CMD_WR_IN: begin
                    wr_a    = sel_a;
                    wr_b    = sel_b;
                    wr_gain = (addr == `DD_ADDR_GAIN);
                end
                `DD_CMD_UPD: begin
                    upd_a = sel_a;
                    upd_b = sel_b;
                end
                `DD_CMD_WR_UPD_ALL: begin
                    wr_a  = sel_a;
                    wr_b  = sel_b;
                    // A reserved address updates nothing at all.
                    upd_a = sel_a | sel_b;
                    upd_b = sel_a | sel_b;
                end
                `DD_CMD_WR_UPD_N: begin
                    wr_a  = sel_a;
                    wr_b  = sel_b;
                    upd_a = sel_a;
                    upd_b = sel_b;
                end
                `DD_CMD_SW_RESET: sw_reset = 1'b1;
                default: ;
            endcase
        end
    end

    // Clear always overrides any input or DAC register write landing in the same cycle.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            in_a_q  <= CLR_CODE;
            in_b_q  <= CLR_CODE;
            dac_a_q <= CLR_CODE;
            dac_b_q <= CLR_CODE;
        end else if (clear_fall || sw_reset) begin
            in_a_q  <= CLR_CODE;
            in_b_q  <= CLR_CODE;
            dac_a_q <= CLR_CODE;
            dac_b_q <= CLR_CODE;
        end else begin
            if (wr_a) begin
                in_a_q <= data;
            end
            if (wr_b) begin
                in_b_q <= data;
            end
            if (upd_a) begin
                dac_a_q <= wr_a ? data : in_a_q;
            end else if (load_dac_n_fall && !load_dac_n_off_q[0]) begin
                dac_a_q <= in_a_q;
            end
            if (upd_b) begin
                dac_b_q <= wr_b ? data : in_b_q;
            end else if (load_dac_n_fall && !load_dac_n_off_q[1]) begin
                dac_b_q <= in_b_q;
            end
        end
    end

    // Mode registers; a software reset returns them to power-on values.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gain_two_q   <= 2'h0;
            power_mode_q <= 4'h0;
            load_dac_n_off_q   <= 2'h0;
            ref_en_q     <= 1'b0;
        end else if (sw_reset) begin
            gain_two_q   <= 2'h0;
            power_mode_q <= 4'h0;
            load_dac_n_off_q   <= 2'h0;
            ref_en_q     <= 1'b0;
        end else if (exec_q) begin
            if (wr_gain) begin
                gain_two_q <= data[1:0];
            end
            if (cmd == `DD_CMD_POWER) begin
                if (data[0]) begin
                    power_mode_q[1:0] <= data[5:4];
                end
                if (data[1]) begin
                    power_mode_q[3:2] <= data[5:4];
                end
            end
            if (cmd == `DD_CMD_LOAD_DAC_N_SET) begin
                load_dac_n_off_q <= data[1:0];
            end
            if (cmd == `DD_CMD_REF) begin
                ref_en_q <= data[0];
            end
        end
    end

    // Clear mode ends only on a frame that started after clear was entered.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clear_mode_q <= 1'b0;
            clr_armed_q  <= 1'b0;
        end else if (clear_fall) begin
            clear_mode_q <= 1'b1;
            clr_armed_q  <= 1'b0;
        end else begin
            // Arming comes last so a new frame's select edge is never lost to an exit.
            if (exec_q && clr_armed_q) begin
                clear_mode_q <= 1'b0;
                clr_armed_q  <= 1'b0;
            end
            if (frame_fall && clear_mode_q) begin
                clr_armed_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_done_q <= 1'b0;
        end else begin
            frame_done_q <= exec_q;
        end
    end
endmodule : dd_dev_end

// ---- design/dd_host_end.sv ----
// Host end: sends 24-bit frames and clear/load pulses on software command.
// Assumes a software master on the plain register port in the core_clk domain.
`timescale 1ns/1ns
`include "dd_consts.svh"
module dd_host_end
    import dd_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst,
    dd_link_if.host     link,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0] reg_rdata_q
);
    dd_tx_e      tx_q;
    logic [23:0] word_q;
    logic [4:0]  bits_q;
    logic [7:0]  tmr_q;
    logic [7:0]  clr_tmr_q;
    logic [7:0]  load_dac_n_tmr_q;
    logic        sync_n_q;
    logic        sclk_q;
    logic        din_q;
    logic        clr_n_q;
    logic        load_dac_n_n_q;

    assign link.sync_n     = sync_n_q;
    assign link.sclk       = sclk_q;
    assign link.din        = din_q;
    assign link.clear_in_n = clr_n_q;
    assign link.load_dac_n = load_dac_n_n_q;

    // Half period of at least 60 ns keeps the serial clock below 50 MHz.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_q     <= DD_TX_IDLE;
            word_q   <= 24'h000000;
            bits_q   <= 5'h00;
            tmr_q    <= 8'h00;
            sync_n_q <= 1'b1;
            sclk_q   <= 1'b1;
            din_q    <= 1'b0;
        end else begin
            if (tmr_q != 8'h00) begin
                tmr_q <= tmr_q - 8'h01;
            end
            unique case (tx_q)
                DD_TX_IDLE: begin
                    if (reg_wr && reg_addr == `DD_HREG_WORD && tmr_q == 8'h00) begin
                        tx_q     <= DD_TX_LEAD;
                        word_q   <= {reg_wdata[22:0], 1'b0};
                        din_q    <= reg_wdata[23];
                        sync_n_q <= 1'b0;
                        bits_q   <= 5'h00;
                        tmr_q    <= `DD_HALF_CYC;
                    end
                end
                DD_TX_LEAD, DD_TX_HIGH: begin
                    if (tmr_q == 8'h00) begin
                        tx_q   <= DD_TX_LOW;
                        sclk_q <= 1'b0;
                        bits_q <= bits_q + 5'h01;
                        tmr_q  <= `DD_HALF_CYC;
                    end
                end
                DD_TX_LOW: begin
                    if (tmr_q == 8'h00) begin
                        sclk_q <= 1'b1;
                        tmr_q  <= `DD_HALF_CYC;
                        if (bits_q == `DD_WORD_BITS) begin
                            tx_q <= DD_TX_TAIL;
                        end else begin
                            tx_q   <= DD_TX_HIGH;
                            din_q  <= word_q[23];
                            word_q <= {word_q[22:0], 1'b0};
                        end
                    end
                end
                DD_TX_TAIL: begin
                    if (tmr_q == 8'h00) begin
                        tx_q     <= DD_TX_IDLE;
                        sync_n_q <= 1'b1;
                        tmr_q    <= `DD_GAP_CYC;
                    end
                end
                default: tx_q <= DD_TX_IDLE;
            endcase
        end
    end

    // Clear and load pulses are active-low for a fixed width.
    // The pins come from flops so that no decode glitch reaches the far edge detector.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clr_tmr_q  <= 8'h00;
            load_dac_n_tmr_q <= 8'h00;
            clr_n_q    <= 1'b1;
            load_dac_n_n_q   <= 1'b1;
        end else begin
            clr_n_q  <= (clr_tmr_q == 8'h00);
            load_dac_n_n_q <= (load_dac_n_tmr_q == 8'h00);
            if (reg_wr && reg_addr == `DD_HREG_CTRL && reg_wdata[0]) begin
                clr_tmr_q <= `DD_PULSE_CYC;
            end else if (clr_tmr_q != 8'h00) begin
                clr_tmr_q <= clr_tmr_q - 8'h01;
            end
            if (reg_wr && reg_addr == `DD_HREG_CTRL && reg_wdata[1]) begin
                load_dac_n_tmr_q <= `DD_PULSE_CYC;
            end else if (load_dac_n_tmr_q != 8'h00) begin
                load_dac_n_tmr_q <= load_dac_n_tmr_q - 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd && reg_addr == `DD_HREG_STAT) begin
            reg_rdata_q <= {31'h00000000, (tx_q != DD_TX_IDLE) || (tmr_q != 8'h00)};
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end
endmodule : dd_host_end

// ---- inc/dd_consts.svh ----
// Constants shared by both ends of the dual converter serial write link.
// Assumes a 100 MHz core clock on both ends; included by bare name.
// Functional notes
// - Reference stays off until reference command.
// - Zero variant: power-up DAC registers all zero.
// - Mid variant: power-up DAC registers mid-scale.
// - Defaults: pin load, powered, ref off, gain one.
// - Clear falling edge forces clear values immediately.
// - Clear mode ends at next frame's 24th edge.
// - Clear mid-frame still overwrites registers at once.
// - 24-bit word: ignore top two, command, address, data.
// - Most significant bit shifted first.
// - Data code left-aligned in 16-bit field.
// - Codes are straight binary, FFFFh full scale.
// - Frame starts low; sample on sclk falling edge.
// - Host serial clock at most 50 MHz.
// - Shift register locks after 24th falling edge.
// - Decode and execute right after 24th edge.
// - Host keeps minimum gap before next frame.
// - Early frame-select rise resets interface, no transfer.
// - Rise before 24th edge discards frame entirely.
// - Command codes decoded per eight-entry table.
// - Address codes: A, B, gain, both, rest reserved.
`ifndef DD_CONSTS_SVH
`define DD_CONSTS_SVH
`define DD_WORD_BITS      5'h18
`define DD_CMD_HI         21
`define DD_CMD_LO         19
`define DD_ADDR_HI        18
`define DD_ADDR_LO        16
`define DD_ZERO_CODE      16'h0000
`define DD_MID_CODE       16'h8000
`define DD_CMD_WR_IN      3'h0
`define DD_CMD_UPD        3'h1
`define DD_CMD_WR_UPD_ALL 3'h2
`define DD_CMD_WR_UPD_N   3'h3
`define DD_CMD_POWER      3'h4
`define DD_CMD_SW_RESET   3'h5
`define DD_CMD_LOAD_DAC_N_SET   3'h6
`define DD_CMD_REF        3'h7
`define DD_ADDR_A         3'h0
`define DD_ADDR_B         3'h1
`define DD_ADDR_GAIN      3'h2
`define DD_ADDR_BOTH      3'h7
`define DD_CORE_PERIOD_NS 10
`define DD_SCLK_HALF_NS   60
`define DD_GAP_NS         100
`define DD_PULSE_NS       100
`define DD_HALF_CYC  8'((`DD_SCLK_HALF_NS + `DD_CORE_PERIOD_NS - 1) / `DD_CORE_PERIOD_NS)
`define DD_GAP_CYC   8'((`DD_GAP_NS + `DD_CORE_PERIOD_NS - 1) / `DD_CORE_PERIOD_NS)
`define DD_PULSE_CYC 8'((`DD_PULSE_NS + `DD_CORE_PERIOD_NS - 1) / `DD_CORE_PERIOD_NS)
`define DD_HREG_WORD      4'h0
`define DD_HREG_STAT      4'h4
`define DD_HREG_CTRL      4'h8
`endif

// ---- inc/dd_link_if.sv ----
// Interface carrying the write-only serial link from host to converter.
// All wires are driven by the host end, or by the bench itself on its second link.
`timescale 1ns/1ns
interface dd_link_if;
    logic sync_n;
    logic sclk;
    logic din;
    logic clear_in_n;
    logic load_dac_n;
    modport dev  (input  sync_n, input  sclk, input  din, input  clear_in_n, input  load_dac_n);
    modport host (output sync_n, output sclk, output din, output clear_in_n, output load_dac_n);
endinterface : dd_link_if

// ---- inc/dd_pkg.sv ----
// Types shared by both ends of the serial write link.
// Assumes dd_consts.svh for all numeric constants.
package dd_pkg;
    typedef enum logic [1:0] {
        DD_RX_IDLE   = 2'h0,
        DD_RX_SHIFT  = 2'h1,
        DD_RX_LOCKED = 2'h3
    } dd_rx_e;
    typedef enum logic [2:0] {
        DD_TX_IDLE = 3'h0,
        DD_TX_LEAD = 3'h1,
        DD_TX_LOW  = 3'h3,
        DD_TX_HIGH = 3'h2,
        DD_TX_TAIL = 3'h6
    } dd_tx_e;
endpackage : dd_pkg

// ---- sim/dd_link_props.sv ----
// Checker for the host-to-converter serial link and the converter outputs.
// Assumes every input is sampled on core_clk with rst asynchronous, active high.
`timescale 1ns/1ns
`include "dd_consts.svh"
module dd_link_props #(
    parameter bit MIDSCALE = 1'b0
)(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        sync_n,
    input wire logic        sclk,
    input wire logic        din,
    input wire logic        clear_in_n,
    input wire logic [15:0] dac_a_q,
    input wire logic        ref_en_q,
    input wire logic        clear_mode_q,
    input wire logic        frame_done_q
);
    localparam logic [15:0] CLR_CODE = MIDSCALE ? `DD_MID_CODE : `DD_ZERO_CODE;
    logic [4:0] falls_q;
    logic       sclk_prev_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Serial clock falls of the current frame; zeroed while the frame select is high.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            falls_q     <= 5'h00;
            sclk_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk;
            if (sync_n) begin
                falls_q <= 5'h00;
            end else if (sclk_prev_q && !sclk) begin
                falls_q <= falls_q + 5'h01;
            end
        end
    end
    sequence s_low_phase;
        !sclk [*7] ##1 sclk;
    endsequence
    sequence s_done;
        frame_done_q ##1 !frame_done_q;
    endsequence
    property p_idle_high;
        sync_n |-> sclk;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("serial clock low outside a frame");
    property p_low_phase;
        $fell(sclk) |-> s_low_phase;
    endproperty
    a_low_phase: assert property (p_low_phase)
        else $error("serial clock low phase not seven cycles");
    property p_din_hold;
        $fell(sclk) |=> $stable(din) [*5];
    endproperty
    a_din_hold: assert property (p_din_hold)
        else $error("data moved while serial clock low");
    property p_frame_len;
        $rose(sync_n) |-> falls_q == 5'h18;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame did not carry 24 clock falls");
    property p_exec;
        ($fell(sclk) && falls_q == 5'h17) |-> ##[3:7] s_done;
    endproperty
    a_exec: assert property (p_exec)
        else $error("no single done pulse after the last fall");
    property p_ref_cause;
        $rose(ref_en_q) |-> frame_done_q;
    endproperty
    a_ref_cause: assert property (p_ref_cause)
        else $error("reference enabled without a command");
    property p_clear_enter;
        $fell(clear_in_n) |-> ##[2:6] (clear_mode_q && dac_a_q == CLR_CODE);
    endproperty
    a_clear_enter: assert property (p_clear_enter)
        else $error("clear edge did not force clear values");
    property p_clear_exit;
        $fell(clear_mode_q) |-> frame_done_q;
    endproperty
    a_clear_exit: assert property (p_clear_exit)
        else $error("clear mode left outside frame execution");
endmodule : dd_link_props

// ---- sim/testbench.sv ----
// Bench: the host end drives a zero-scale converter end; a mid-scale converter
// end is driven by the bench itself to break framing on purpose.
// Assumes dd_pkg, dd_link_if, both design ends and the checker are compiled first.
`timescale 1ns/1ns
`include "dd_consts.svh"
module testbench;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata_q, s;
    logic [15:0] in_a_q, in_b_q, dac_a_q, dac_b_q, mid_a, mid_b, e_ia, e_ib, e_da, e_db;
    logic [3:0]  power_mode_q, e_pwr;
    logic [1:0]  gain_two_q, load_dac_n_off_q, e_gain, e_load_dac_n;
    logic        ref_en_q, clear_mode_q, frame_done_q, e_ref;
    logic [23:0] w;
    logic [2:0]  addr_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h4};
    int          nb_tab [3] = '{1, 22, 23};
    integer      seed, miscompares = 0, check_count = 0;
    always #5 core_clk = ~core_clk;
    dd_link_if lk1();
    dd_link_if lk2();
    dd_host_end u_dd_host_end (.core_clk, .rst, .link(lk1.host), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_q);
    dd_dev_end #(.MIDSCALE(1'b0)) u_dd_dev_end (.core_clk, .rst, .link(lk1.dev), .in_a_q,
        .in_b_q, .dac_a_q, .dac_b_q, .gain_two_q, .power_mode_q, .load_dac_n_off_q, .ref_en_q,
        .clear_mode_q, .frame_done_q);
    dd_dev_end #(.MIDSCALE(1'b1)) u_dd_dev_end_mid (.core_clk, .rst, .link(lk2.dev),
        .in_a_q(), .in_b_q(), .dac_a_q(mid_a), .dac_b_q(mid_b), .gain_two_q(),
        .power_mode_q(), .load_dac_n_off_q(), .ref_en_q(), .clear_mode_q(), .frame_done_q());
    dd_link_props #(.MIDSCALE(1'b0)) u_dd_link_props (.core_clk, .rst, .sync_n(lk1.sync_n),
        .sclk(lk1.sclk), .din(lk1.din), .clear_in_n(lk1.clear_in_n), .dac_a_q, .ref_en_q,
        .clear_mode_q, .frame_done_q);
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic check_all();
        check("in_a", e_ia, in_a_q);
        check("in_b", e_ib, in_b_q);
        check("dac_a", e_da, dac_a_q);
        check("dac_b", e_db, dac_b_q);
        check("gain", 16'(e_gain), 16'(gain_two_q));
        check("power", 16'(e_pwr), 16'(power_mode_q));
        check("load_dac_n", 16'(e_load_dac_n), 16'(load_dac_n_off_q));
        check("ref", 16'(e_ref), 16'(ref_en_q));
    endtask : check_all
    function automatic void model_reset();
        {e_ia, e_ib, e_da, e_db} = {4{16'h0000}};
        {e_gain, e_load_dac_n, e_pwr, e_ref} = 9'h000;
    endfunction : model_reset
    function automatic void model_apply(input logic [23:0] v);
        logic wa, wb;
        wa = v[18:16] == `DD_ADDR_A || v[18:16] == `DD_ADDR_BOTH;
        wb = v[18:16] == `DD_ADDR_B || v[18:16] == `DD_ADDR_BOTH;
        case (v[21:19])
            `DD_CMD_WR_IN: begin
                if (v[18:16] == `DD_ADDR_GAIN) e_gain = v[1:0];
                if (wa) e_ia = v[15:0];
                if (wb) e_ib = v[15:0];
            end
            `DD_CMD_UPD: begin
                if (wa) e_da = e_ia;
                if (wb) e_db = e_ib;
            end
            `DD_CMD_WR_UPD_ALL: begin
                if (wa) e_ia = v[15:0];
                if (wb) e_ib = v[15:0];
                if (wa || wb) {e_da, e_db} = {e_ia, e_ib};
            end
            `DD_CMD_WR_UPD_N: begin
                if (wa) {e_ia, e_da} = {2{v[15:0]}};
                if (wb) {e_ib, e_db} = {2{v[15:0]}};
            end
            `DD_CMD_POWER: begin
                if (v[0]) e_pwr[1:0] = v[5:4];
                if (v[1]) e_pwr[3:2] = v[5:4];
            end
            `DD_CMD_SW_RESET: model_reset();
            `DD_CMD_LOAD_DAC_N_SET: e_load_dac_n = v[1:0];
            default: e_ref = v[0];
        endcase
    endfunction : model_apply
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 s = reg_rdata_q;
        @(posedge core_clk);
    endtask : reg_read
    task automatic wait_idle();
        int n;
        n = 0;
        s = 32'h1;
        while (s[0] && n < 400) begin
            reg_read(`DD_HREG_STAT);
            n++;
        end
        check("busy", 16'h0000, s[15:0]);
    endtask : wait_idle
    task automatic send_word(input logic [23:0] v);
        reg_write(`DD_HREG_WORD, {8'h00, v});
        wait_idle();
        model_apply(v);
        check_all();
    endtask : send_word
    task automatic pulse_clear();
        reg_write(`DD_HREG_CTRL, 32'h1);
        repeat (10) @(posedge core_clk);
        {e_ia, e_ib, e_da, e_db} = {4{16'h0000}};
        check_all();
        check("clear", 16'h0001, 16'(clear_mode_q));
    endtask : pulse_clear
    // The bench link clock runs at 125 ns, timed apart from core_clk on purpose.
    task automatic bb_frame(input logic [23:0] v, input int nb);
        lk2.sync_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            lk2.din = i < 24 ? v[23 - i] : ~v[i - 24];
            #42 lk2.sclk = 1'b0;
            #62 lk2.sclk = 1'b1;
            #21;
        end
        #60 lk2.sync_n = 1'b1;
        lk2.din = ~lk2.din;
        #300;
    endtask : bb_frame
    initial begin
        seed = 98;
        {lk2.sync_n, lk2.sclk, lk2.din, lk2.clear_in_n, lk2.load_dac_n} = 5'h1B;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        model_reset();
        check_all();
        check("mid_a", 16'h8000, mid_a);
        for (int c = 0; c < 8; c++) begin
            foreach (addr_tab[k]) begin
                w = 24'($random(seed));
                w[21:19] = 3'(c);
                w[18:16] = addr_tab[k];
                send_word(w);
            end
        end
        send_word({2'h3, `DD_CMD_REF, `DD_ADDR_A, 16'h0001});
        send_word({2'h0, `DD_CMD_WR_UPD_N, `DD_ADDR_BOTH, 16'hFFFF});
        // The second word lands while the link is busy and must be dropped.
        w = {2'h0, `DD_CMD_WR_IN, `DD_ADDR_A, 16'h1357};
        reg_write(`DD_HREG_WORD, {8'h00, w});
        reg_write(`DD_HREG_WORD, 32'h0001_2468);
        wait_idle();
        model_apply(w);
        check_all();
        reg_read(4'hC);
        check("unmapped", 16'h0000, s[15:0]);
        pulse_clear();
        send_word({2'h0, `DD_CMD_WR_IN, `DD_ADDR_B, 16'h0BAD});
        check("clear", 16'h0000, 16'(clear_mode_q));
        w = {2'h0, `DD_CMD_WR_UPD_N, `DD_ADDR_A, 16'h0F0F};
        reg_write(`DD_HREG_WORD, {8'h00, w});
        repeat (100) @(posedge core_clk);
        pulse_clear();
        wait_idle();
        model_apply(w);
        check_all();
        check("clear", 16'h0001, 16'(clear_mode_q));
        send_word({2'h0, `DD_CMD_LOAD_DAC_N_SET, `DD_ADDR_A, 16'h0002});
        check("clear", 16'h0000, 16'(clear_mode_q));
        send_word({2'h0, `DD_CMD_WR_IN, `DD_ADDR_BOTH, 16'hA5A5});
        reg_write(`DD_HREG_CTRL, 32'h2);
        repeat (10) @(posedge core_clk);
        e_da = e_ia;
        check_all();
        #3;
        foreach (nb_tab[k]) begin
            bb_frame({2'h0, `DD_CMD_WR_UPD_N, `DD_ADDR_BOTH, 16'h1111}, nb_tab[k]);
            check("mid_a", 16'h8000, mid_a);
        end
        bb_frame({2'h2, `DD_CMD_WR_UPD_N, `DD_ADDR_BOTH, 16'h9C3B}, 29);
        check("mid_a", 16'h9C3B, mid_a);
        check("mid_b", 16'h9C3B, mid_b);
        lk2.clear_in_n = 1'b0;
        #300 lk2.clear_in_n = 1'b1;
        check("mid_a", 16'h8000, mid_a);
        check("mid_b", 16'h8000, mid_b);
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        wrap_up();
    end
endmodule : testbench
